//--- verilog/uar_rx_top.sv
// Notes on behaviour
// - x16 front end, shifter steps per bit
// - async frames only while continuous enable
// - after stop bit, word into FIFO
// - ready flag on load, enable gates irq
// - ready flag read-only, clears when empty
// - two-entry FIFO, reads in order
// - full at stop: overrun set, word lost
// - overrun clears only by enable cycle
// - overrun blocks all FIFO loads
// - low stop majority vote sets framing error
// - error and ninth bit queued per entry
// - nine-bit select gives ninth data bit
// - async when sync clear, port enabled
// - sync master is half-duplex
// - sync select plus enable plus clock source master claims clock pin
// - clock source bit drives shift clock
// - unimplemented bits read zero
// - three-sample majority on ticks 7-9
// - start, 8/9 data LSB first, stop
// - baud clock x16 or x64 of rate
`default_nettype none
module uar_rx_top
  import uar_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
)(
  // Clock, reset, enable
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic              ce,
  // AXI4-Lite write
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Serial pins
  input  wire logic              shift_data_line,
  output logic                   shift_clock_line_out,
  output logic                   shift_clock_line_oe,
  // Transmitter and CPU
  input  wire logic              tx_busy,
  output logic                   tx_permit,
  output logic                   rx_irq
);
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [7:0]      receive_status_ff;
  logic [7:0]      transmit_status_ff;
  logic [7:0]      transmit_buffer_ff;
  logic [7:0]      baud_divisor_ff;
  logic            receive_irq_enable_ff;
  logic            overrun_error_ff;
  logic [7:0]      brg_ff;
  logic [1:0]      quad_ff;
  logic            ck_ff;
  logic            ck_oe_ff;
  uar_rx_state_t   st_ff;
  logic [3:0]      sub_ff;
  logic [3:0]      bits_ff;
  logic [8:0]      rsr_ff;
  logic            prev_ff;
  logic            dec_ff;
  logic            aw_v_ff;
  logic            w_v_ff;
  logic [9:0]      aw_idx_ff;
  logic [7:0]      w_byte_ff;
  logic            w_lane_ff;
  logic            serial_port_enable, sync, continuous_receive_enable, single_receive_enable, rx9, high_speed_baud_select;
  logic            rx_en, brg_run, brg_tick, tick16;
  logic            line, vote, smp_en;
  logic            push_try, push, pop, empty, full, receive_ready_flag;
  logic            wr_go, rd_go;
  logic [9:0]      ar_idx;
  uar_rx_word_t    head, nxt_word;

  assign serial_port_enable = receive_status_ff[B_SERIAL_PORT_ENABLE];
  assign rx9  = receive_status_ff[B_RX9];
  assign single_receive_enable = receive_status_ff[B_SINGLE_RECEIVE_ENABLE];
  assign continuous_receive_enable = receive_status_ff[B_CONTINUOUS_RECEIVE_ENABLE];
  assign sync = transmit_status_ff[B_SYNC];
  assign high_speed_baud_select = transmit_status_ff[B_HIGH_SPEED_BAUD_SELECT];

  function automatic logic hit(input logic [9:0] idx, input logic [9:0] reg_idx);
    hit = (idx == reg_idx);
  endfunction

  // ----------------------------------------
  // Mode selection
  // ----------------------------------------
  assign rx_en     = serial_port_enable && !sync && continuous_receive_enable;
  // Receiving owns the port in sync mode; the transmitter must hold off
  assign tx_permit = serial_port_enable && transmit_status_ff[B_TXEN] && !(sync && (continuous_receive_enable || single_receive_enable));

  // ----------------------------------------
  // Baud generator
  // ----------------------------------------
  // Held in reload while nothing uses it, so the first tick is a full period
  assign brg_run  = serial_port_enable && (continuous_receive_enable || single_receive_enable || transmit_status_ff[B_TXEN]);
  assign brg_tick = brg_run && (brg_ff == RST_ZERO);
  assign tick16   = brg_tick && (high_speed_baud_select || quad_ff == HS_LAST);

  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      brg_ff <= RST_ZERO;
    else if (ce)
      brg_ff <= (!brg_run || brg_tick) ? baud_divisor_ff : brg_ff - 1'b1;

  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      quad_ff <= '0;
    else if (ce)
      quad_ff <= !brg_run ? '0 : quad_ff + 2'(brg_tick);

  // ----------------------------------------
  // Synchronous master clock pin
  // ----------------------------------------
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      ck_ff    <= 1'b1;
      ck_oe_ff <= 1'b0;
    end
    else if (ce)
    begin
      ck_oe_ff <= serial_port_enable && sync && transmit_status_ff[B_CLOCK_SOURCE_MASTER];
      if (!(serial_port_enable && sync))
        ck_ff <= 1'b1;
      else if (brg_tick && (tx_busy || continuous_receive_enable || single_receive_enable))
        ck_ff <= ~ck_ff;
    end

  assign shift_clock_line_out = ck_ff;
  assign shift_clock_line_oe  = ck_oe_ff;

  // ----------------------------------------
  // Receive front end
  // ----------------------------------------
  assign smp_en = tick16 && (st_ff != RX_IDLE) && (sub_ff >= SMP_FIRST)
               && (sub_ff <= SMP_LAST);

  uar_rx_sampler u_smp (
    .clk    (clk),
    .nrst   (nrst),
    .ce     (ce),
    .pin    (shift_data_line),
    .smp_en (smp_en),
    .line   (line),
    .vote   (vote)
  );

  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      prev_ff <= 1'b1;
      dec_ff  <= 1'b0;
    end
    else if (ce)
    begin
      prev_ff <= line;
      dec_ff  <= tick16 && (st_ff != RX_IDLE) && (sub_ff == SMP_LAST);
    end

  // ----------------------------------------
  // Frame sequencer
  // ----------------------------------------
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      sub_ff <= '0;
    else if (ce)
    begin
      if (st_ff == RX_IDLE)
        sub_ff <= '0;
      else if (tick16)
        sub_ff <= (sub_ff == OVS_LAST) ? '0 : sub_ff + 1'b1;
    end

  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      st_ff   <= RX_IDLE;
      bits_ff <= '0;
      rsr_ff  <= '0;
    end
    else if (ce)
    begin
      if (!rx_en)
        st_ff <= RX_IDLE;
      else
        case (st_ff)
          RX_IDLE:
            if (prev_ff && !line)
              st_ff <= RX_START;
          RX_START:
            if (dec_ff)
            begin
              // A high centre majority vote is a glitch, not a start bit
              st_ff   <= vote ? RX_IDLE : RX_DATA;
              bits_ff <= '0;
            end
          RX_DATA:
            if (dec_ff)
            begin
              rsr_ff  <= {vote, rsr_ff[8:1]};
              bits_ff <= bits_ff + 1'b1;
              if (bits_ff == (rx9 ? BITS_9 : BITS_8) - 1'b1)
                st_ff <= RX_STOP;
            end
          RX_STOP:
            if (dec_ff)
              st_ff <= RX_IDLE;
          default:
            st_ff <= RX_IDLE;
        endcase
    end

  // ----------------------------------------
  // Word hand-off and overrun
  // ----------------------------------------
  assign push_try = ce && dec_ff && (st_ff == RX_STOP) && rx_en;
  assign push     = push_try && !full && !overrun_error_ff;

  always_comb
  begin
    nxt_word.framing_error  = !vote;
    nxt_word.ninth = rx9 && rsr_ff[8];
    nxt_word.data  = rx9 ? rsr_ff[7:0] : rsr_ff[8:1];
  end

  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      overrun_error_ff <= 1'b0;
    else if (ce)
    begin
      if (!continuous_receive_enable)
        overrun_error_ff <= 1'b0;
      else if (push_try && full)
        overrun_error_ff <= 1'b1;
    end

  uar_rx_fifo #(
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk     (clk),
    .nrst    (nrst),
    .ce      (ce),
    .push    (push),
    .wr_word (nxt_word),
    .pop     (pop),
    .head    (head),
    .empty   (empty),
    .full    (full)
  );

  assign receive_ready_flag   = !empty;
  assign rx_irq = receive_ready_flag && receive_irq_enable_ff;

  // ----------------------------------------
  // AXI4-Lite write side
  // ----------------------------------------
  assign s_axi_awready = ce && !aw_v_ff;
  assign s_axi_wready  = ce && !w_v_ff;
  assign wr_go         = ce && aw_v_ff && w_v_ff && !s_axi_bvalid;

  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      aw_v_ff   <= 1'b0;
      aw_idx_ff <= '0;
      w_v_ff    <= 1'b0;
      w_byte_ff <= RST_ZERO;
      w_lane_ff <= 1'b0;
    end
    else if (ce)
    begin
      if (s_axi_awvalid && !aw_v_ff)
      begin
        aw_v_ff   <= 1'b1;
        aw_idx_ff <= s_axi_awaddr[ADDR_W-1:2];
      end
      else if (wr_go)
        aw_v_ff <= 1'b0;
      if (s_axi_wvalid && !w_v_ff)
      begin
        w_v_ff    <= 1'b1;
        w_byte_ff <= s_axi_wdata[7:0];
        w_lane_ff <= s_axi_wstrb[0];
      end
      else if (wr_go)
        w_v_ff <= 1'b0;
    end

  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end
    else if (ce)
    begin
      if (wr_go)
      begin
        s_axi_bvalid <= 1'b1;
        if (hit(aw_idx_ff, IDX_PIR) || hit(aw_idx_ff, IDX_RECEIVE_STATUS)
            || hit(aw_idx_ff, IDX_TRANSMIT_BUFFER) || hit(aw_idx_ff, IDX_RECEIVE_BUFFER)
            || hit(aw_idx_ff, IDX_PIE) || hit(aw_idx_ff, IDX_TRANSMIT_STATUS)
            || hit(aw_idx_ff, IDX_BAUD_DIVISOR))
          s_axi_bresp <= RESP_OKAY;
        else
          s_axi_bresp <= RESP_DEC;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end

  // Status flags and the receive buffer ignore writes
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      receive_status_ff <= RST_ZERO;
      transmit_status_ff <= RST_TRANSMIT_STATUS;
      transmit_buffer_ff <= RST_ZERO;
      baud_divisor_ff <= RST_ZERO;
      receive_irq_enable_ff  <= 1'b0;
    end
    else if (wr_go && w_lane_ff)
    begin
      if (hit(aw_idx_ff, IDX_RECEIVE_STATUS))
        receive_status_ff <= w_byte_ff & RECEIVE_STATUS_WMASK;
      else if (hit(aw_idx_ff, IDX_TRANSMIT_STATUS))
        transmit_status_ff <= w_byte_ff & TRANSMIT_STATUS_WMASK;
      else if (hit(aw_idx_ff, IDX_TRANSMIT_BUFFER))
        transmit_buffer_ff <= w_byte_ff;
      else if (hit(aw_idx_ff, IDX_BAUD_DIVISOR))
        baud_divisor_ff <= w_byte_ff;
      else if (hit(aw_idx_ff, IDX_PIE))
        receive_irq_enable_ff <= w_byte_ff[B_RECEIVE_IRQ_ENABLE];
    end

  // ----------------------------------------
  // AXI4-Lite read side
  // ----------------------------------------
  assign s_axi_arready = ce && !s_axi_rvalid;
  assign rd_go         = s_axi_arvalid && s_axi_arready;
  assign ar_idx        = s_axi_araddr[ADDR_W-1:2];
  assign pop           = rd_go && hit(ar_idx, IDX_RECEIVE_BUFFER);

  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end
    else if (ce)
    begin
      if (rd_go)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= RESP_OKAY;
        s_axi_rdata  <= '0;
        if (hit(ar_idx, IDX_PIR))
          s_axi_rdata[B_RECEIVE_READY_FLAG] <= receive_ready_flag;
        else if (hit(ar_idx, IDX_RECEIVE_STATUS))
        begin
          s_axi_rdata[7:4]    <= receive_status_ff[7:4];
          s_axi_rdata[B_FRAMING_ERROR] <= !empty && head.framing_error;
          s_axi_rdata[B_OVERRUN_ERROR] <= overrun_error_ff;
          s_axi_rdata[B_NINTH_RECEIVED_BIT] <= !empty && head.ninth;
        end
        else if (hit(ar_idx, IDX_TRANSMIT_BUFFER))
          s_axi_rdata[7:0] <= transmit_buffer_ff;
        else if (hit(ar_idx, IDX_RECEIVE_BUFFER))
          s_axi_rdata[7:0] <= head.data;
        else if (hit(ar_idx, IDX_PIE))
          s_axi_rdata[B_RECEIVE_IRQ_ENABLE] <= receive_irq_enable_ff;
        else if (hit(ar_idx, IDX_TRANSMIT_STATUS))
        begin
          s_axi_rdata[7:0]    <= transmit_status_ff;
          s_axi_rdata[B_TRMT] <= !tx_busy;
        end
        else if (hit(ar_idx, IDX_BAUD_DIVISOR))
          s_axi_rdata[7:0] <= baud_divisor_ff;
        else
          s_axi_rresp <= RESP_DEC;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_idle_off;
    ce && !rx_en |=> (st_ff == RX_IDLE);
  endproperty
  a_idle_off: assert property (p_idle_off) else $error("frame taken while disabled");

  property p_ready_set;
    push |=> receive_ready_flag;
  endproperty
  a_ready_set: assert property (p_ready_set) else $error("ready flag not set");

  property p_ready_clear;
    $fell(receive_ready_flag) |-> $past(pop);
  endproperty
  a_ready_clear: assert property (p_ready_clear) else $error("flag cleared w/o read");

  property p_two_deep;
    ce && push && !pop && !empty |=> full;
  endproperty
  a_two_deep: assert property (p_two_deep) else $error("second word not held");

  property p_overrun;
    push_try && full && continuous_receive_enable |=> overrun_error_ff;
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not flagged");

  property p_overrun_error_hold;
    $fell(overrun_error_ff) |-> !$past(continuous_receive_enable);
  endproperty
  a_overrun_error_hold: assert property (p_overrun_error_hold) else $error("overrun cleared early");

  property p_block;
    overrun_error_ff && !pop |=> $stable(empty) && $stable(full);
  endproperty
  a_block: assert property (p_block) else $error("load during overrun");

  property p_framing_error;
    push && empty |=> (head.framing_error != $past(vote));
  endproperty
  a_framing_error: assert property (p_framing_error) else $error("framing bit wrong");

  property p_centre;
    dec_ff |-> $past(sub_ff) == SMP_LAST;
  endproperty
  a_centre: assert property (p_centre) else $error("decision off centre");

  property p_half_duplex;
    sync && continuous_receive_enable |-> !tx_permit;
  endproperty
  a_half_duplex: assert property (p_half_duplex) else $error("tx while receiving");
endmodule
`default_nettype wire

//--- verilog/uar_pkg.sv
`default_nettype none
package uar_pkg;
  // ----------------------------------------
  // Register indexes (byte address = 4 * index)
  // ----------------------------------------
  localparam int         ADDR_W       = 12;
  localparam logic [9:0] IDX_PIR      = 10'h00C;
  localparam logic [9:0] IDX_RECEIVE_STATUS    = 10'h018;
  localparam logic [9:0] IDX_TRANSMIT_BUFFER    = 10'h019;
  localparam logic [9:0] IDX_RECEIVE_BUFFER    = 10'h01A;
  localparam logic [9:0] IDX_PIE      = 10'h08C;
  localparam logic [9:0] IDX_TRANSMIT_STATUS    = 10'h098;
  localparam logic [9:0] IDX_BAUD_DIVISOR    = 10'h099;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int B_SERIAL_PORT_ENABLE = 7;
  localparam int B_RX9  = 6;
  localparam int B_SINGLE_RECEIVE_ENABLE = 5;
  localparam int B_CONTINUOUS_RECEIVE_ENABLE = 4;
  localparam int B_FRAMING_ERROR = 2;
  localparam int B_OVERRUN_ERROR = 1;
  localparam int B_NINTH_RECEIVED_BIT = 0;
  localparam int B_CLOCK_SOURCE_MASTER = 7;
  localparam int B_TXEN = 5;
  localparam int B_SYNC = 4;
  localparam int B_HIGH_SPEED_BAUD_SELECT = 2;
  localparam int B_TRMT = 1;
  localparam int B_RECEIVE_READY_FLAG = 5;
  localparam int B_RECEIVE_IRQ_ENABLE = 5;
  // ----------------------------------------
  // Reset values and write masks
  // ----------------------------------------
  localparam logic [7:0] RST_ZERO    = 8'h00;
  localparam logic [7:0] RST_TRANSMIT_STATUS   = 8'h02;
  localparam logic [7:0] RECEIVE_STATUS_WMASK = 8'hF0;
  localparam logic [7:0] TRANSMIT_STATUS_WMASK = 8'hF5;
  // ----------------------------------------
  // Sampling and sizes
  // ----------------------------------------
  localparam logic [3:0] OVS_LAST   = 4'hF;
  localparam logic [3:0] SMP_FIRST  = 4'h6;
  localparam logic [3:0] SMP_LAST   = 4'h8;
  localparam logic [1:0] HS_LAST    = 2'h3;
  localparam logic [3:0] BITS_8     = 4'h8;
  localparam logic [3:0] BITS_9     = 4'h9;
  localparam int         FIFO_DEPTH = 2;
  localparam logic [1:0] RESP_OKAY  = 2'h0;
  localparam logic [1:0] RESP_DEC   = 2'h3;

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} uar_rx_state_t;

  typedef struct packed {
    logic       framing_error;
    logic       ninth;
    logic [7:0] data;
  } uar_rx_word_t;
endpackage
`default_nettype wire

//--- verilog/uar_rx_sampler.sv
`default_nettype none
module uar_rx_sampler
  import uar_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic ce,
  // Line
  input  wire logic pin,
  input  wire logic smp_en,
  output logic      line,
  output logic      vote
);
  logic       meta_ff;
  logic       line_ff;
  logic [2:0] smp_ff;

  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      meta_ff <= 1'b1;
      line_ff <= 1'b1;
    end
    else if (ce)
    begin
      meta_ff <= pin;
      line_ff <= meta_ff;
    end

  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      smp_ff <= 3'h7;
    else if (ce && smp_en)
      smp_ff <= {smp_ff[1:0], line_ff};

  assign line = line_ff;
  assign vote = (smp_ff[0] & smp_ff[1]) | (smp_ff[0] & smp_ff[2])
              | (smp_ff[1] & smp_ff[2]);
endmodule
`default_nettype wire

//--- verilog/uar_rx_fifo.sv
`default_nettype none
module uar_rx_fifo
  import uar_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
)(
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic         ce,
  // Queue
  input  wire logic         push,
  input  wire uar_rx_word_t wr_word,
  input  wire logic         pop,
  output uar_rx_word_t      head,
  output logic              empty,
  output logic              full
);
  localparam int PW = $clog2(DEPTH);

  uar_rx_word_t  mem_ff [DEPTH];
  logic [PW-1:0] wp_ff;
  logic [PW-1:0] rp_ff;
  logic [PW:0]   cnt_ff;

  assign empty = (cnt_ff == '0);
  assign full  = (cnt_ff == (PW+1)'(DEPTH));
  assign head  = mem_ff[rp_ff];

  function automatic logic [PW-1:0] inc(input logic [PW-1:0] p);
    inc = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      for (int i = 0; i < DEPTH; i++)
        mem_ff[i] <= '0;
    else if (ce && push && !full)
      mem_ff[wp_ff] <= wr_word;

  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      wp_ff  <= '0;
      rp_ff  <= '0;
      cnt_ff <= '0;
    end
    else if (ce)
    begin
      if (push && !full)
        wp_ff <= inc(wp_ff);
      if (pop && !empty)
        rp_ff <= inc(rp_ff);
      cnt_ff <= cnt_ff + (PW+1)'(push && !full) - (PW+1)'(pop && !empty);
    end
endmodule
`default_nettype wire

//--- verification/uar_line_drv.sv
`default_nettype none
module uar_line_drv #(
  parameter int CPB = 16
)(
  // Clock
  input  wire logic clk,
  // Serial line
  output logic      line
);
  timeunit 1ns;
  timeprecision 1ps;

  initial line = 1'b1;

  // ----------------------------------------
  // One frame: start, data LSB first, stop
  // ----------------------------------------
  task automatic send(input logic [8:0] w, input int nbits, input logic stop);
    int i;
    @(posedge clk);
    line <= 1'b0;
    repeat (CPB) @(posedge clk);
    for (i = 0; i < nbits; i++)
    begin
      line <= w[i];
      repeat (CPB) @(posedge clk);
    end
    line <= stop;
    repeat (CPB) @(posedge clk);
    // Idle high between frames, two bit times
    line <= 1'b1;
    repeat (2 * CPB) @(posedge clk);
  endtask
endmodule
`default_nettype wire

//--- verification/testbench.sv
`default_nettype none
module testbench
  import uar_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {logic [11:0] a; logic [31:0] d; logic [1:0] r;} uar_row_t;

  logic clk, nrst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, ck_out, ck_oe, tx_permit, rx_irq, rx_line;
  logic        ck_prev, tx_busy;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd_val;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rd_resp;
  int          failures, cmp_count, i;
  // Reset values per address; bits above 7 must read zero
  uar_row_t    rows [8] = '{'{12'h030, 32'h0, 2'h0}, '{12'h060, 32'h0, 2'h0},
                            '{12'h064, 32'h0, 2'h0}, '{12'h068, 32'h0, 2'h0},
                            '{12'h230, 32'h0, 2'h0}, '{12'h260, 32'h2, 2'h0},
                            '{12'h264, 32'h0, 2'h0}, '{12'h004, 32'h0, 2'h3}};

  uar_rx_top dut (.clk(clk), .nrst(nrst), .ce(1'b1), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .shift_data_line(rx_line), .shift_clock_line_out(ck_out),
    .shift_clock_line_oe(ck_oe), .tx_busy(tx_busy), .tx_permit(tx_permit), .rx_irq(rx_irq));

  uar_line_drv #(.CPB(16)) txm (.clk(clk), .line(rx_line));

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ----------------------------------------
  // AXI4-Lite master; readies sampled settled before the edge
  // ----------------------------------------
  task automatic wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] resp);
    logic ta, tw, da, dw;
    da = 1'b0;
    dw = 1'b0;
    awaddr  <= a;
    wdata   <= {24'h000000, d};
    wstrb   <= 4'hF;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    // Each channel is released at its own handshake edge
    while (!(da && dw))
    begin
      @(negedge clk);
      ta = !da && (awready === 1'b1);
      tw = !dw && (wready === 1'b1);
      @(posedge clk);
      if (ta)
        awvalid <= 1'b0;
      if (tw)
        wvalid <= 1'b0;
      da = da | ta;
      dw = dw | tw;
    end
    do
      @(negedge clk);
    while (bvalid !== 1'b1);
    resp = bresp;
    // Ready stays high, so back-to-back calls never drive it twice at one edge
    @(posedge clk);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] resp);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    @(negedge clk);
    while (arready !== 1'b1)
      @(negedge clk);
    @(posedge clk);
    arvalid <= 1'b0;
    @(negedge clk);
    while (rvalid !== 1'b1)
      @(negedge clk);
    d    = rdata;
    resp = rresp;
    @(posedge clk);
  endtask

  task automatic expect_rd(input string nm, input logic [11:0] a, input logic [31:0] e);
    rd(a, rd_val, rd_resp);
    chk(nm, rd_val, e);
  endtask

  task automatic w(input logic [11:0] a, input logic [7:0] d);
    wr(a, d, rd_resp);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    failures = 0;
    cmp_count = 0;
    {nrst, awvalid, wvalid, bready, arvalid, rready, tx_busy} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    for (i = 0; i < 8; i++)
    begin
      rd(rows[i].a, rd_val, rd_resp);
      chk("reset data", rd_val, rows[i].d);
      chk("reset resp", {30'h0, rd_resp}, {30'h0, rows[i].r});
    end
    wr(12'h004, 8'hFF, rd_resp);
    chk("unmapped bresp", {30'h0, rd_resp}, {30'h0, RESP_DEC});
    // Fastest rate: divisor 0, high speed, 16 clocks per bit
    w(12'h264, 8'h00);
    w(12'h260, 8'h24);
    chk("tx permit", {31'h0, tx_permit}, 32'h0);
    w(12'h060, 8'h90);
    chk("tx permit", {31'h0, tx_permit}, 32'h1);
    w(12'h230, 8'h20);
    expect_rd("transmit_status", 12'h260, 32'h26);
    txm.send(9'h0A5, 8, 1'b1);
    repeat (4) @(posedge clk);
    chk("irq", {31'h0, rx_irq}, 32'h1);
    wr(12'h030, 8'h00, rd_resp);
    chk("pir bresp", {30'h0, rd_resp}, {30'h0, RESP_OKAY});
    expect_rd("pir ready", 12'h030, 32'h20);
    expect_rd("receive_status", 12'h060, 32'h90);
    expect_rd("data", 12'h068, 32'hA5);
    expect_rd("pir empty", 12'h030, 32'h0);
    chk("irq off", {31'h0, rx_irq}, 32'h0);
    // Two held, third overruns; second has a low stop
    txm.send(9'h011, 8, 1'b1);
    txm.send(9'h022, 8, 1'b0);
    txm.send(9'h033, 8, 1'b1);
    repeat (4) @(posedge clk);
    expect_rd("receive_status ovr", 12'h060, 32'h92);
    expect_rd("first", 12'h068, 32'h11);
    expect_rd("receive_status framing_error", 12'h060, 32'h96);
    expect_rd("second", 12'h068, 32'h22);
    txm.send(9'h044, 8, 1'b1);
    repeat (4) @(posedge clk);
    expect_rd("blocked", 12'h030, 32'h0);
    expect_rd("ovr kept", 12'h060, 32'h92);
    w(12'h060, 8'h80);
    w(12'h060, 8'h90);
    expect_rd("ovr clr", 12'h060, 32'h90);
    // Nine data bits
    w(12'h060, 8'hD0);
    txm.send(9'h15A, 9, 1'b1);
    repeat (4) @(posedge clk);
    expect_rd("ninth", 12'h060, 32'hD1);
    expect_rd("data9", 12'h068, 32'h5A);
    // Receiver off: frame ignored
    w(12'h060, 8'h80);
    txm.send(9'h077, 8, 1'b1);
    repeat (4) @(posedge clk);
    expect_rd("continuous_receive_enable off", 12'h030, 32'h0);
    // Sync master: clock pin claimed and running, half-duplex
    w(12'h260, 8'hB4);
    tx_busy <= 1'b1;
    @(negedge clk);
    chk("ck oe", {31'h0, ck_oe}, 32'h1);
    chk("tx permit sync", {31'h0, tx_permit}, 32'h1);
    ck_prev = ck_out;
    @(negedge clk);
    chk("ck toggles", {31'h0, ck_out ^ ck_prev}, 32'h1);
    @(posedge clk);
    expect_rd("transmit_status sync", 12'h260, 32'hB4);
    tx_busy <= 1'b0;
    w(12'h060, 8'h90);
    chk("half duplex", {31'h0, tx_permit}, 32'h0);
    // Reset in mid-run
    nrst <= 1'b0;
    repeat (3) @(posedge clk);
    chk("rst ck oe", {31'h0, ck_oe}, 32'h0);
    chk("rst ck", {31'h0, ck_out}, 32'h1);
    chk("rst permit", {31'h0, tx_permit}, 32'h0);
    nrst <= 1'b1;
    @(posedge clk);
    expect_rd("rst receive_status", 12'h060, 32'h0);
    expect_rd("rst transmit_status", 12'h260, 32'h2);
    wrap_up();
  end

  initial
  begin
    repeat (30000) @(posedge clk);
    failures++;
    wrap_up();
  end
endmodule
`default_nettype wire
